// >>> rtl/p1io_port.sv
// Purpose: Port 1 general I/O with alternate pin functions
// Assumes: Single 125 MHz clock, asynchronous active-high reset
// Notes: Pin output enables are active low
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`include "p1io_params.svh"
module p1io_port
    import p1io_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n,
    output logic [WIDTH-1:0] pin_pullup,
    input wire p1io_alt_out_t alt_out,
    output p1io_alt_in_t alt_in
);
    p1io_bus_t bus;
    logic [7:0] mode_r, mode_nxt;
    logic [7:0] data_r, data_nxt;
    logic [7:0] pull_r, pull_nxt;
    logic [7:0] dir_r, dir_nxt;
    logic [2:0] edge_r, edge_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] pin_sync;
    logic [7:0] out_nxt, oe_n_nxt, pu_nxt;
    logic [2:0] irq_pulse;
    logic [2:0] irq_lvl_nxt;
    logic capt_nxt;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            p1io_sync u_sync (
                .clk(clk),
                .reset(reset),
                .d(pin_in[gi]),
                .q(pin_sync[gi])
            );
        end
        for (gi = 0; gi < 3; gi++) begin : g_edge
            p1io_edge u_edge (
                .clk(clk),
                .reset(reset),
                .en(mode_r[`P1IO_BIT_EXT_ONE + gi]),
                .rise_sel(edge_r[gi]),
                .d(pin_sync[`P1IO_BIT_EXT_ONE + gi]),
                .pulse(irq_pulse[gi])
            );
        end
    endgenerate

    // Register writes
    always_comb begin
        mode_nxt = mode_r;
        data_nxt = data_r;
        pull_nxt = pull_r;
        dir_nxt = dir_r;
        edge_nxt = edge_r;
        if (bus.wr) begin
            case (bus.addr)
                `P1IO_ADDR_MODE: mode_nxt = bus.wdata;
                `P1IO_ADDR_DATA: data_nxt = bus.wdata;
                `P1IO_ADDR_PULL: pull_nxt = bus.wdata;
                `P1IO_ADDR_DIR: dir_nxt = bus.wdata;
                `P1IO_ADDR_EDGE: edge_nxt = bus.wdata[2:0];
                default: ;
            endcase
        end
    end

    // Register reads, data valid the cycle after rd
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `P1IO_ADDR_MODE: rdata_nxt = mode_r;
                `P1IO_ADDR_DATA: begin
                    for (int i = 0; i < 8; i++) begin
                        rdata_nxt[i] = dir_r[i] ? data_r[i] : pin_sync[i];
                    end
                end
                `P1IO_ADDR_PULL: rdata_nxt = pull_r;
                `P1IO_ADDR_DIR: rdata_nxt = `P1IO_DIR_READ;
                `P1IO_ADDR_EDGE: rdata_nxt = {5'h00, edge_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Pin drive selection
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            out_nxt[i] = data_r[i];
            oe_n_nxt[i] = !dir_r[i];
            pu_nxt[i] = pull_r[i] && !dir_r[i];
        end
        if (mode_r[`P1IO_BIT_TA_CLK]) begin
            out_nxt[0] = alt_out.timer_a_clock_out;
            oe_n_nxt[0] = 1'b0;
            pu_nxt[0] = 1'b0;
        end
        if (mode_r[`P1IO_BIT_TF_LOW]) begin
            out_nxt[1] = alt_out.timer_f_low_compare_out;
            oe_n_nxt[1] = 1'b0;
            pu_nxt[1] = 1'b0;
        end
        if (mode_r[`P1IO_BIT_TF_HIGH]) begin
            out_nxt[2] = alt_out.timer_f_high_compare_out;
            oe_n_nxt[2] = 1'b0;
            pu_nxt[2] = 1'b0;
        end
        if (mode_r[`P1IO_BIT_CAPT]) begin
            out_nxt[3] = 1'b0;
            oe_n_nxt[3] = 1'b1;
            pu_nxt[3] = pull_r[3];
        end
        if (mode_r[`P1IO_BIT_PWM]) begin
            out_nxt[4] = alt_out.pwm_out;
            oe_n_nxt[4] = 1'b0;
            pu_nxt[4] = 1'b0;
        end
        for (int k = 5; k < 8; k++) begin
            if (mode_r[k]) begin
                out_nxt[k] = 1'b0;
                oe_n_nxt[k] = 1'b1;
                pu_nxt[k] = pull_r[k];
            end
        end
        capt_nxt = mode_r[`P1IO_BIT_CAPT] & pin_sync[3];
        irq_lvl_nxt = mode_r[7:5] & pin_sync[7:5];
    end

    // Register file
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_r <= `P1IO_RESET_VAL;
            data_r <= `P1IO_RESET_VAL;
            pull_r <= `P1IO_RESET_VAL;
            dir_r <= `P1IO_RESET_VAL;
            edge_r <= 3'h0;
        end else begin
            mode_r <= mode_nxt;
            data_r <= data_nxt;
            pull_r <= pull_nxt;
            dir_r <= dir_nxt;
            edge_r <= edge_nxt;
        end
    end

    // Read data, zero outside the cycle after a read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    // Pin drive and peripheral inputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out <= 8'h00;
            pin_oe_n <= 8'hff;
            pin_pullup <= 8'h00;
            alt_in <= '0;
        end else begin
            pin_out <= out_nxt;
            pin_oe_n <= oe_n_nxt;
            pin_pullup <= pu_nxt;
            alt_in.irq_level <= irq_lvl_nxt;
            alt_in.irq_edge <= irq_pulse;
            alt_in.timer_g_capture_input <= capt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    dir_read_ones_a: assert property (
        rd && addr == `P1IO_ADDR_DIR |=> rdata == 8'hff)
        else $error("direction read not all ones");
    data_write_a: assert property (
        wr && addr == `P1IO_ADDR_DATA |=> data_r == $past(wdata))
        else $error("data latch not updated");
    out_read_latch_a: assert property (
        rd && addr == `P1IO_ADDR_DATA && dir_r[0] |=> rdata[0] == $past(data_r[0]))
        else $error("output pin read not latch");
    in_read_pin_a: assert property (
        rd && addr == `P1IO_ADDR_DATA && !dir_r[0] |=> rdata[0] == $past(pin_sync[0]))
        else $error("input pin read not pin");
    gpio_drive_a: assert property (
        !mode_r[4] && dir_r[4] |=> !pin_oe_n[4] && pin_out[4] == $past(data_r[4]))
        else $error("gpio output not driven");
    pull_off_out_a: assert property (
        dir_r[2] && !mode_r[2] |=> !pin_pullup[2])
        else $error("pull-up on output pin");
    pull_on_in_a: assert property (
        !dir_r[6] && pull_r[6] |=> pin_pullup[6])
        else $error("pull-up not enabled");
    pwm_route_a: assert property (
        mode_r[4] |=> !pin_oe_n[4] && pin_out[4] == $past(alt_out.pwm_out))
        else $error("pwm not routed");
    irq_input_a: assert property (
        mode_r[7] |=> pin_oe_n[7])
        else $error("interrupt pin driven");
    ta_clock_route_a: assert property (
        mode_r[0] |=> pin_out[0] == $past(alt_out.timer_a_clock_out))
        else $error("timer A clock not routed");

    reset_clear_a: assert property (
        $fell(reset) |-> mode_r == 8'h00 && data_r == 8'h00 && pull_r == 8'h00
            && dir_r == 8'h00 && pin_oe_n == 8'hff && pin_pullup == 8'h00)
        else $error("registers not cleared by reset");
    mode_write_a: assert property (
        wr && addr == `P1IO_ADDR_MODE |=> mode_r == $past(wdata))
        else $error("mode register not updated");
    pull_write_a: assert property (
        wr && addr == `P1IO_ADDR_PULL |=> pull_r == $past(wdata))
        else $error("pull-up register not updated");
    dir_write_a: assert property (
        wr && addr == `P1IO_ADDR_DIR |=> dir_r == $past(wdata))
        else $error("direction register not updated");
    edge_write_a: assert property (
        wr && addr == `P1IO_ADDR_EDGE |=> edge_r == $past(wdata[2:0]))
        else $error("edge select not updated");
    mode_read_a: assert property (
        rd && addr == `P1IO_ADDR_MODE |=> rdata == $past(mode_r))
        else $error("mode read wrong");
    read_all_bits_a: assert property (
        rd && addr == `P1IO_ADDR_DATA
            |=> rdata == $past((dir_r & data_r) | (~dir_r & pin_sync)))
        else $error("port read wrong");

    gpio_input_a: assert property (
        !mode_r[3] && !dir_r[3] |=> pin_oe_n[3])
        else $error("gpio input driven");
    alt_ignores_dir_a: assert property (
        mode_r[0] && !dir_r[0] |=> !pin_oe_n[0])
        else $error("alternate output follows direction");
    alt_input_dir_a: assert property (
        mode_r[5] && dir_r[5] |=> pin_oe_n[5])
        else $error("alternate input follows direction");
    tf_low_route_a: assert property (
        mode_r[1] |=> !pin_oe_n[1] && pin_out[1] == $past(alt_out.timer_f_low_compare_out))
        else $error("timer F low compare not routed");
    tf_high_route_a: assert property (
        mode_r[2] |=> !pin_oe_n[2] && pin_out[2] == $past(alt_out.timer_f_high_compare_out))
        else $error("timer F high compare not routed");
    pwm_pull_off_a: assert property (
        mode_r[4] |=> !pin_pullup[4])
        else $error("pull-up on pwm pin");
    pull_never_driven_a: assert property (
        (pin_pullup & ~pin_oe_n) == 8'h00)
        else $error("pull-up on driven pin");

    capture_input_a: assert property (
        mode_r[3] |=> pin_oe_n[3] && alt_in.timer_g_capture_input == $past(pin_sync[3]))
        else $error("capture input not routed");
    capture_off_a: assert property (
        !mode_r[3] |=> !alt_in.timer_g_capture_input)
        else $error("capture input active in gpio mode");
    irq_one_level_a: assert property (
        mode_r[5] |=> pin_oe_n[5] && alt_in.irq_level[0] == $past(pin_sync[5]))
        else $error("interrupt 1 level not routed");
    irq_two_level_a: assert property (
        mode_r[6] |=> pin_oe_n[6] && alt_in.irq_level[1] == $past(pin_sync[6]))
        else $error("interrupt 2 level not routed");
    irq_three_level_a: assert property (
        mode_r[7] |=> alt_in.irq_level[2] == $past(pin_sync[7]))
        else $error("interrupt 3 level not routed");
    rise_edge_a: assert property (
        mode_r[5] && edge_r[0] && pin_sync[5] && !$past(pin_sync[5])
            |-> ##2 alt_in.irq_edge[0])
        else $error("rising edge missed");
    fall_edge_a: assert property (
        mode_r[7] && !edge_r[2] && !pin_sync[7] && $past(pin_sync[7])
            |-> ##2 alt_in.irq_edge[2])
        else $error("falling edge missed");
    no_edge_gpio_a: assert property (
        !mode_r[6] |-> ##2 !alt_in.irq_edge[1])
        else $error("edge pulse in gpio mode");

    mode_write_c: cover property (wr && addr == `P1IO_ADDR_MODE ##1 mode_r != 8'h00);
    edge_seen_c: cover property (irq_pulse != 3'h0);
    pin_read_c: cover property (rd && addr == `P1IO_ADDR_DATA ##1 rdata != 8'h00);
    capture_seen_c: cover property (alt_in.timer_g_capture_input);
    alt_drive_c: cover property (mode_r[4] && !pin_oe_n[4]);
endmodule : p1io_port

// >>> include/p1io_params.svh
// Purpose: Offsets, reset values and field positions of the port 1 block
// Assumes: 16-bit register address, 8-bit data
// Notes: Included by the port module and the bench
`ifndef P1IO_PARAMS_SVH
`define P1IO_PARAMS_SVH
`define P1IO_ADDR_MODE 16'hffc8
`define P1IO_ADDR_DATA 16'hffd4
`define P1IO_ADDR_PULL 16'hffe0
`define P1IO_ADDR_DIR 16'hffe4
`define P1IO_ADDR_EDGE 16'hffe8
`define P1IO_RESET_VAL 8'h00
`define P1IO_DIR_READ 8'hff
`define P1IO_BIT_TA_CLK 0
`define P1IO_BIT_TF_LOW 1
`define P1IO_BIT_TF_HIGH 2
`define P1IO_BIT_CAPT 3
`define P1IO_BIT_PWM 4
`define P1IO_BIT_EXT_ONE 5
`define P1IO_BIT_EXT_TWO 6
`define P1IO_BIT_EXT_THREE 7
`endif

// >>> include/p1io_pkg.sv
// Purpose: Types shared by the port 1 modules
// Assumes: Nothing
// Notes: Constants live in p1io_params.svh
package p1io_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } p1io_bus_t;
    typedef struct packed {
        logic timer_a_clock_out;
        logic timer_f_high_compare_out;
        logic timer_f_low_compare_out;
        logic pwm_out;
    } p1io_alt_out_t;
    typedef struct packed {
        logic [2:0] irq_level;
        logic [2:0] irq_edge;
        logic timer_g_capture_input;
    } p1io_alt_in_t;
endpackage : p1io_pkg

// >>> rtl/p1io_sync.sv
// Purpose: Two-flop synchroniser for one pin
// Assumes: Pin is asynchronous to clk
// Notes: First flop feeds only the second
`timescale 1ns/1ns
module p1io_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule : p1io_sync

// >>> rtl/p1io_edge.sv
// Purpose: Edge detector with selectable polarity for one event input
// Assumes: Input is already synchronised
// Notes: Pulse one cycle on chosen edge while enabled
`timescale 1ns/1ns
module p1io_edge (
    input wire logic clk,
    input wire logic reset,
    input wire logic en,
    input wire logic rise_sel,
    input wire logic d,
    output logic pulse
);
    logic prev_r;
    logic prev_nxt;
    logic pulse_nxt;
    always_comb begin
        prev_nxt = d;
        pulse_nxt = en && (rise_sel ? (d && !prev_r) : (!d && prev_r));
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_r <= 1'b0;
            pulse <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            pulse <= pulse_nxt;
        end
    end
endmodule : p1io_edge

// >>> bench/p1io_pad_model.sv
// Purpose: Pads and far-side sources of port 1
// Assumes: A driven pin wins over the outside source
// Notes: An undriven pin with no outside source and no pull-up toggles each cycle
`timescale 1ns/1ns
module p1io_pad_model (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_v,
    output logic [7:0] pad
);
    logic [7:0] flt_r = 8'h00;
    always_ff @(posedge clk) flt_r <= ~flt_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pad[i] = pin_out[i];
            else if (ext_en[i]) pad[i] = ext_v[i];
            else if (pin_pullup[i]) pad[i] = 1'b1;
            else pad[i] = flt_r[i];
        end
    end
endmodule : p1io_pad_model

// >>> bench/port1_pin_function_io_test.sv
// Purpose: Self-checking bench of the port 1 block
// Assumes: Register model kept in the bench
// Notes: Only pins of known level are compared
`timescale 1ns/1ns
`include "p1io_params.svh"
module port1_pin_function_io_test
    import p1io_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, pin_out, pin_oe_n, pin_pullup, pad, gp, ao, ai, p, kn;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_v = 8'h00;
    p1io_alt_out_t alt_out = '0;
    p1io_alt_in_t alt_in;
    logic [7:0] m_mode = 8'h00;
    logic [7:0] m_data = 8'h00;
    logic [7:0] m_pull = 8'h00;
    logic [7:0] m_dir = 8'h00;
    int failures = 0;
    int total_checks = 0;
    int seed = 32'ha641d30a;
    int c [3];
    initial begin
        forever #4 clk = ~clk;
    end
    p1io_port u_p1io_port (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pad), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .alt_out(alt_out), .alt_in(alt_in));
    p1io_pad_model u_p1io_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_v(ext_v), .pad(pad));
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr_reg(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        case (a)
            `P1IO_ADDR_MODE: m_mode = d;
            `P1IO_ADDR_DATA: m_data = d;
            `P1IO_ADDR_PULL: m_pull = d;
            `P1IO_ADDR_DIR: m_dir = d;
            default: ;
        endcase
    endtask : wr_reg
    task automatic rd_chk(logic [15:0] a, logic [7:0] msk, logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", exp & msk, rdata & msk);
    endtask : rd_chk
    task automatic edge_chk(logic [7:0] v, logic [2:0] e);
        @(posedge clk);
        ext_v <= v;
        c = '{0, 0, 0};
        repeat (8) begin
            @(posedge clk);
            #1;
            for (int k = 0; k < 3; k++) c[k] += alt_in.irq_edge[k];
        end
        check("edges", {2'b00, 2'(e[2]), 2'(e[1]), 2'(e[0])},
              8'(c[0] + c[1] * 4 + c[2] * 16));
    endtask : edge_chk
    task automatic conclude();
        $display("Counts: %0d checks, %0d failures", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        #1;
        check("oe_n", 8'hff, pin_oe_n);
        check("pullup", 8'h00, pin_pullup);
        rd_chk(`P1IO_ADDR_MODE, 8'hff, 8'h00);
        rd_chk(`P1IO_ADDR_PULL, 8'hff, 8'h00);
        wr_reg(`P1IO_ADDR_DIR, 8'hff);
        rd_chk(`P1IO_ADDR_DATA, 8'hff, 8'h00);
        $display("test reset done");
        repeat (40) begin
            wr_reg(`P1IO_ADDR_MODE, 8'($random(seed)));
            wr_reg(`P1IO_ADDR_DIR, 8'($random(seed)));
            wr_reg(`P1IO_ADDR_DATA, 8'($random(seed)));
            wr_reg(`P1IO_ADDR_PULL, 8'($random(seed)));
            ext_en <= 8'($random(seed));
            ext_v <= 8'($random(seed));
            alt_out <= 4'($random(seed));
            repeat (5) @(posedge clk);
            #1;
            gp = ~m_mode;
            ao = m_mode & 8'h17;
            ai = m_mode & 8'he8;
            p = (ext_en & ext_v) | (~ext_en & m_pull);
            kn = ext_en | m_pull;
            check("oe_n", ~((gp & m_dir) | ao), pin_oe_n);
            check("out", ((gp & m_dir & m_data) | (ao & {3'b000, alt_out.pwm_out, 1'b0,
                  alt_out.timer_f_high_compare_out, alt_out.timer_f_low_compare_out,
                  alt_out.timer_a_clock_out})), pin_out & ~pin_oe_n);
            check("pullup", (gp & ~m_dir & m_pull) | (ai & m_pull), pin_pullup);
            check("alt_in", {4'h0, p[7:5] & m_mode[7:5] & kn[7:5], p[3] & m_mode[3] & kn[3]},
                  {4'h0, alt_in.irq_level & kn[7:5], alt_in.timer_g_capture_input & kn[3]});
            rd_chk(`P1IO_ADDR_DATA, gp & (m_dir | kn), (m_dir & m_data) | (~m_dir & p));
            rd_chk(`P1IO_ADDR_MODE, 8'hff, m_mode);
            rd_chk(`P1IO_ADDR_PULL, 8'hff, m_pull);
            rd_chk(`P1IO_ADDR_DIR, 8'hff, `P1IO_DIR_READ);
            rd_chk(16'hffd0, 8'hff, 8'h00);
        end
        $display("test random done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        m_mode = 8'h00;
        m_data = 8'h00;
        m_pull = 8'h00;
        m_dir = 8'h00;
        #1;
        check("oe_n", 8'hff, pin_oe_n);
        check("pullup", 8'h00, pin_pullup);
        rd_chk(`P1IO_ADDR_MODE, 8'hff, 8'h00);
        rd_chk(`P1IO_ADDR_PULL, 8'hff, 8'h00);
        $display("test mid reset done");
        @(posedge clk);
        ext_en <= 8'he0;
        ext_v <= 8'h00;
        wr_reg(`P1IO_ADDR_MODE, 8'he0);
        for (int e = 0; e < 8; e++) begin
            wr_reg(`P1IO_ADDR_EDGE, 8'(e));
            edge_chk(8'he0, 3'(e));
            edge_chk(8'h00, ~3'(e));
        end
        $display("test edge done");
        conclude();
    end
endmodule : port1_pin_function_io_test
